// File: src/fdr_core.sv
// Instruction decode and Q1..Q4 timing core with read-modify-write file access.
`default_nettype none
`include "fdr_defines.svh"
module fdr_core
  import fdr_pkg::*;
#(
  parameter int PC_W  = 13,
  parameter int STK_D = 8
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Program memory
  output logic [PC_W-1:0]      prog_addr_o,
  input  wire logic [13:0]     prog_data_i,
  // Port pins
  input  wire logic [7:0]      port_pin_i,
  output logic [7:0]           port_out_o,
  output logic                 port_change_flag_o,
  // Core state
  output logic [7:0]           w_o,
  output logic                 carry_o,
  output logic                 zero_o,
  output logic                 file_rd_o
);

  localparam int SP_W = $clog2(STK_D);

  fdr_phase_e                  ph, next_ph;
  fdr_bub_e                    bub, next_bub;
  logic [13:0]                 ir, next_ir;
  logic [7:0]                  opnd, next_opnd;
  logic [7:0]                  w, next_w;
  logic                        c, next_c;
  logic                        z, next_z;
  logic [PC_W-1:0]             pc, next_pc;
  logic [PC_W-1:0]             pc_inc;
  logic [STK_D-1:0][PC_W-1:0]  stack, next_stack;
  logic [SP_W-1:0]             sp, next_sp;
  logic [7:0]                  port_out, next_port_out;
  logic [7:0]                  port_latch, next_port_latch;
  logic                        flag, next_flag;
  logic                        rd, next_rd;
  logic [7:0]                  pin_m, pin_s;
  fdr_dec_s                    d;
  logic                        file_op;
  logic                        is_port;
  logic                        ctl_ret;
  logic [7:0]                  res;
  logic [8:0]                  sum9;
  logic [7:0]                  mask;
  logic                        wr_f;
  logic                        wr_w;
  logic                        upd_z;
  logic                        skip;
  logic                        jmp;
  logic                        mem_we;
  logic [7:0]                  mem_rdata;

  // Pin synchroniser; only the second stage is read by logic
  always_ff @(posedge clk_i) begin
    pin_m <= port_pin_i;
    pin_s <= pin_m;
  end

  assign d       = fdr_decode(ir);                                          // [RULE_01]
  assign is_port = (d.faddr == `FDR_PORT_ADDR);                             // [RULE_04]
  assign ctl_ret = (d.faddr == `FDR_CTL_RETURN) || (d.faddr == `FDR_CTL_RETFIE);
  assign pc_inc  = PC_W'(pc + 1'b1);
  assign mask    = `FDR_BIT_ONE << d.bitsel;                                // [RULE_05]

  // Clear and move-to-file with destination 0 are accumulator or control forms
  always_comb begin
    file_op = 1'b0;
    case (d.cat)                                                            // [RULE_02]
      FDR_CAT_BYTE: file_op = d.dest ||
                              ((d.op != `FDR_OP_MOVWF) && (d.op != `FDR_OP_CLR));  // [RULE_10]
      FDR_CAT_BIT:  file_op = 1'b1;                                         // [RULE_10]
      default:      file_op = 1'b0;
    endcase
  end

  fdr_file_mem #(
    .AW (7),
    .DW (8)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (d.faddr),
    .wdata_i (res),
    .raddr_i (d.faddr),
    .rdata_o (mem_rdata)
  );

  // Execute stage: arithmetic, destination and flow decisions for Q4
  always_comb begin
    res   = `FDR_BYTE_ZERO;
    sum9  = {1'b0, `FDR_BYTE_ZERO};
    wr_f  = 1'b0;
    wr_w  = 1'b0;
    upd_z = 1'b0;
    skip  = 1'b0;
    jmp   = 1'b0;
    case (d.cat)
      FDR_CAT_BYTE: begin                                                   // [RULE_13]
        wr_f  = d.dest;                                                     // [RULE_03]
        wr_w  = !d.dest;                                                    // [RULE_03]
        upd_z = 1'b1;
        case (d.op)
          `FDR_OP_MOVWF: begin
            res   = w;
            wr_w  = 1'b0;
            upd_z = 1'b0;
            jmp   = !d.dest && ctl_ret;
          end
          `FDR_OP_CLR:   res = `FDR_BYTE_ZERO;                              // [RULE_12]
          `FDR_OP_SUB: begin
            sum9 = {1'b0, opnd} + {1'b0, ~w} + 9'h001;
            res  = sum9[7:0];
          end
          `FDR_OP_DEC:   res = opnd - 8'h01;
          `FDR_OP_IOR:   res = opnd | w;
          `FDR_OP_AND:   res = opnd & w;
          `FDR_OP_XOR:   res = opnd ^ w;
          `FDR_OP_ADD: begin
            sum9 = {1'b0, opnd} + {1'b0, w};
            res  = sum9[7:0];
          end
          `FDR_OP_MOV:   res = opnd;
          `FDR_OP_COM:   res = ~opnd;
          `FDR_OP_INC:   res = opnd + 8'h01;
          `FDR_OP_DECSZ: begin
            res   = opnd - 8'h01;
            upd_z = 1'b0;
            skip  = (res == `FDR_BYTE_ZERO);                                // [RULE_09]
          end
          `FDR_OP_RR: begin
            res   = {c, opnd[7:1]};
            upd_z = 1'b0;
          end
          `FDR_OP_RL: begin
            res   = {opnd[6:0], c};
            upd_z = 1'b0;
          end
          `FDR_OP_SWAP: begin
            res   = {opnd[3:0], opnd[7:4]};
            upd_z = 1'b0;
          end
          `FDR_OP_INCSZ: begin
            res   = opnd + 8'h01;
            upd_z = 1'b0;
            skip  = (res == `FDR_BYTE_ZERO);                                // [RULE_09]
          end
          default: res = opnd;
        endcase
      end
      FDR_CAT_BIT: begin                                                    // [RULE_14]
        res = opnd;
        case (d.op[3:2])
          `FDR_BOP_CLR: begin
            res  = opnd & ~mask;                                            // [RULE_05]
            wr_f = 1'b1;
          end
          `FDR_BOP_SET: begin
            res  = opnd | mask;                                             // [RULE_05]
            wr_f = 1'b1;
          end
          `FDR_BOP_TSC: skip = ((opnd & mask) == `FDR_BYTE_ZERO);           // [RULE_09]
          `FDR_BOP_TSS: skip = ((opnd & mask) != `FDR_BYTE_ZERO);           // [RULE_09]
          default:      skip = 1'b0;
        endcase
      end
      FDR_CAT_JUMP: jmp = 1'b1;                                             // [RULE_06]
      FDR_CAT_LIT: begin                                                    // [RULE_15]
        wr_w  = 1'b1;                                                       // [RULE_07]
        upd_z = 1'b1;
        casez (d.op)                                                        // [RULE_12]
          `FDR_LOP_MOVLW: begin
            res   = d.lit8;                                                 // [RULE_06]
            upd_z = 1'b0;
          end
          `FDR_LOP_RETLW: begin
            res   = d.lit8;
            upd_z = 1'b0;
            jmp   = 1'b1;
          end
          `FDR_LOP_IORLW: res = d.lit8 | w;
          `FDR_LOP_ANDLW: res = d.lit8 & w;
          `FDR_LOP_XORLW: res = d.lit8 ^ w;
          `FDR_LOP_SUBLW: begin
            sum9 = {1'b0, d.lit8} + {1'b0, ~w} + 9'h001;
            res  = sum9[7:0];
          end
          `FDR_LOP_ADDLW: begin
            sum9 = {1'b0, d.lit8} + {1'b0, w};
            res  = sum9[7:0];
          end
          default: res = w;
        endcase
      end
      default: res = `FDR_BYTE_ZERO;
    endcase
  end

  // Sequencer: one instruction cycle is Q1..Q4, four clocks
  always_comb begin
    next_ph         = fdr_phase_e'(ph + 2'h1);                              // [RULE_08]
    next_bub        = bub;
    next_ir         = ir;
    next_opnd       = opnd;
    next_w          = w;
    next_c          = c;
    next_z          = z;
    next_pc         = pc;
    next_stack      = stack;
    next_sp         = sp;
    next_port_out   = port_out;
    next_port_latch = port_latch;
    next_rd         = 1'b0;
    mem_we          = 1'b0;
    next_flag       = (pin_s != port_latch);
    case (ph)
      FDR_Q1: next_ir = prog_data_i;
      FDR_Q2: begin
        if (file_op && (bub == FDR_BUB_NONE)) begin
          next_rd = 1'b1;                                                   // [RULE_10]
          if (is_port) begin
            next_port_latch = pin_s;                                        // [RULE_11]
          end
        end
      end
      FDR_Q3: next_opnd = is_port ? pin_s : mem_rdata;                      // [RULE_10]
      FDR_Q4: begin
        next_bub = FDR_BUB_NONE;
        if (bub == FDR_BUB_SKIP) begin
          next_pc = pc_inc;                                                 // [RULE_09]
        end else if (bub == FDR_BUB_NONE) begin
          next_pc = pc_inc;
          if (wr_f && file_op) begin
            if (is_port) begin
              next_port_out = res;
            end else begin
              mem_we = 1'b1;                                                // [RULE_03]
            end
          end else if (wr_w) begin
            next_w = res;                                                   // [RULE_07]
          end
          if (upd_z) begin
            next_z = (res == `FDR_BYTE_ZERO);
          end
          if ((d.cat == FDR_CAT_BYTE && (d.op == `FDR_OP_SUB || d.op == `FDR_OP_ADD)) ||
              (d.cat == FDR_CAT_LIT && d.op[3:2] == 2'b11)) begin
            next_c = sum9[8];
          end else if (d.cat == FDR_CAT_BYTE && d.op == `FDR_OP_RR) begin
            next_c = opnd[0];
          end else if (d.cat == FDR_CAT_BYTE && d.op == `FDR_OP_RL) begin
            next_c = opnd[7];
          end
          if (skip) begin
            next_bub = FDR_BUB_SKIP;                                        // [RULE_09]
          end
          if (jmp) begin
            next_bub = FDR_BUB_JUMP;                                        // [RULE_09]
            if (d.cat == FDR_CAT_JUMP) begin
              next_pc = PC_W'(d.lit11);                                     // [RULE_06]
              if (!d.op[3]) begin
                next_stack[sp] = pc_inc;
                next_sp        = SP_W'(sp + 1'b1);
              end
            end else begin
              next_pc = stack[sp - 1'b1];
              next_sp = SP_W'(sp - 1'b1);
            end
          end
        end
      end
      default: next_ph = FDR_Q1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ph         <= FDR_Q1;
      bub        <= FDR_BUB_NONE;
      ir         <= 14'h0000;
      opnd       <= `FDR_BYTE_ZERO;
      w          <= `FDR_W_RST;
      c          <= 1'b0;
      z          <= 1'b0;
      pc         <= `FDR_PC_RST;
      stack      <= '0;
      sp         <= '0;
      port_out   <= `FDR_BYTE_ZERO;
      port_latch <= `FDR_BYTE_ZERO;
      flag       <= 1'b0;
      rd         <= 1'b0;
    end else begin
      ph         <= next_ph;
      bub        <= next_bub;
      ir         <= next_ir;
      opnd       <= next_opnd;
      w          <= next_w;
      c          <= next_c;
      z          <= next_z;
      pc         <= next_pc;
      stack      <= next_stack;
      sp         <= next_sp;
      port_out   <= next_port_out;
      port_latch <= next_port_latch;
      flag       <= next_flag;
      rd         <= next_rd;
    end
  end

  assign prog_addr_o        = pc;
  assign port_out_o         = port_out;
  assign port_change_flag_o = flag;
  assign w_o                = w;
  assign carry_o            = c;
  assign zero_o             = z;
  assign file_rd_o          = rd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_quad;
    ph == FDR_Q2 ##1 ph == FDR_Q3 ##1 ph == FDR_Q4 ##1 ph == FDR_Q1;
  endsequence

  sequence s_q4_plain;
    ph == FDR_Q4 && bub == FDR_BUB_NONE;
  endsequence

  AST_PHASE_FOUR: assert property (ph == FDR_Q1 |=> s_quad)                 // [RULE_08]
    else $error("instruction cycle is not four clocks");
  AST_PC_ONLY_Q4: assert property (ph != FDR_Q4 |=> pc == $past(pc))        // [RULE_09]
    else $error("program counter moved outside Q4");
  AST_JUMP_HOLD: assert property (ph == FDR_Q4 && bub == FDR_BUB_JUMP |=> // [RULE_09]
                                  pc == $past(pc))
    else $error("program counter moved in jump dummy cycle");
  AST_BUB_NOWRITE: assert property (bub != FDR_BUB_NONE |-> !mem_we && next_w == w) // [RULE_09]
    else $error("dummy cycle changed state");
  AST_SKIP_THEN_NOP: assert property (s_q4_plain ##0 (skip && !jmp) |=> // [RULE_09]
                                      (bub == FDR_BUB_SKIP) [*4])
    else $error("true skip did not yield one dummy cycle");
  AST_READ_BEFORE_WRITE: assert property (mem_we |-> // [RULE_10]
                                          $past(rd) && $past(ph) == FDR_Q3)
    else $error("file write without preceding read");
  AST_PORT_READ_LATCH: assert property (ph == FDR_Q2 && file_op && is_port && // [RULE_11]
                                        bub == FDR_BUB_NONE |=> port_latch == $past(pin_s))
    else $error("port read did not end mismatch");
  AST_DEST_W: assert property (s_q4_plain ##0 (d.cat == FDR_CAT_BYTE && !d.dest && // [RULE_03]
                               d.op != `FDR_OP_MOVWF) |=> w == $past(res))
    else $error("destination 0 did not load accumulator");
  AST_DEST_F: assert property (s_q4_plain ##0 (d.cat == FDR_CAT_BYTE && d.dest && // [RULE_03]
                               !is_port) |-> mem_we)
    else $error("destination 1 did not write file");
  AST_BIT_ONLY: assert property (mem_we && d.cat == FDR_CAT_BIT |-> // [RULE_05]
                                 ((res ^ opnd) & ~mask) == `FDR_BYTE_ZERO)
    else $error("bit operation touched other bits");

endmodule : fdr_core
`default_nettype wire

// File: src/fdr_defines.svh
// Constants shared by the instruction format decoder and its core.
// Functional notes
// [RULE_01] Every instruction is one 14-bit word holding an operation code and operand fields.
// [RULE_02] Each word falls into exactly one of the byte, bit, or literal/control categories.
// [RULE_03] In byte operations destination 0 stores the result in the accumulator, 1 in the file.
// [RULE_04] The file address field selects one register of the range 0x00 to 0x7f.
// [RULE_05] In bit operations the bit select field picks one bit of the addressed 8-bit register.
// [RULE_06] Literal and control operations carry an 8-bit or an 11-bit constant.
// [RULE_07] A working accumulator serves as implicit operand and possible result destination.
// [RULE_08] One instruction cycle is exactly four consecutive oscillator periods.
// [RULE_09] A true skip test or a program counter change adds a second cycle run as a no-operation.
// [RULE_10] Any instruction naming a file register reads it before modifying and storing it.
// [RULE_11] A clearing write still reads the port, so that read ends a pending change mismatch.
// [RULE_12] Don't-care bits of an encoding never change what the instruction does.
// [RULE_13] Byte operations are top bits 00, a 4-bit code, the destination bit and a 7-bit address.
// [RULE_14] Bit operations are top bits 01, a 2-bit code, a 3-bit bit select and a 7-bit address.
// [RULE_15] Literal and control encodings follow the usual mid-range table within the 14-bit word.
`ifndef FDR_DEFINES_SVH
`define FDR_DEFINES_SVH

// Field positions in the instruction word
`define FDR_CAT_MSB   13
`define FDR_CAT_LSB   12
`define FDR_OP_MSB    11
`define FDR_OP_LSB    8
`define FDR_DEST_BIT  7
`define FDR_BSEL_MSB  9
`define FDR_BSEL_LSB  7
`define FDR_FA_MSB    6
`define FDR_LIT8_MSB  7
`define FDR_LIT11_MSB 10

// Byte operation codes
`define FDR_OP_MOVWF  4'h0
`define FDR_OP_CLR    4'h1
`define FDR_OP_SUB    4'h2
`define FDR_OP_DEC    4'h3
`define FDR_OP_IOR    4'h4
`define FDR_OP_AND    4'h5
`define FDR_OP_XOR    4'h6
`define FDR_OP_ADD    4'h7
`define FDR_OP_MOV    4'h8
`define FDR_OP_COM    4'h9
`define FDR_OP_INC    4'ha
`define FDR_OP_DECSZ  4'hb
`define FDR_OP_RR     4'hc
`define FDR_OP_RL     4'hd
`define FDR_OP_SWAP   4'he
`define FDR_OP_INCSZ  4'hf

// Bit operation codes (upper two bits of the code field)
`define FDR_BOP_CLR   2'h0
`define FDR_BOP_SET   2'h1
`define FDR_BOP_TSC   2'h2
`define FDR_BOP_TSS   2'h3

// Literal operation codes, don't-care bits as wildcards
`define FDR_LOP_MOVLW 4'b00??
`define FDR_LOP_RETLW 4'b01??
`define FDR_LOP_IORLW 4'b1000
`define FDR_LOP_ANDLW 4'b1001
`define FDR_LOP_XORLW 4'b1010
`define FDR_LOP_SUBLW 4'b110?
`define FDR_LOP_ADDLW 4'b111?

// Control words inside byte code 0 with destination 0
`define FDR_CTL_RETURN 7'h08
`define FDR_CTL_RETFIE 7'h09

// Miscellaneous
`define FDR_PORT_ADDR 7'h06
`define FDR_PC_RST    13'h0000
`define FDR_W_RST     8'h00
`define FDR_BYTE_ZERO 8'h00
`define FDR_BIT_ONE   8'h01

`endif

// File: src/fdr_file_mem.sv
// File register storage with registered read data.
`default_nettype none
module fdr_file_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output var  logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // Contents are not reset; software initialises them as on the device
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : fdr_file_mem
`default_nettype wire

// File: src/fdr_pkg.sv
// Types and the word decoder shared by the core.
`default_nettype none
`include "fdr_defines.svh"
package fdr_pkg;

  typedef enum logic [1:0] {
    FDR_CAT_BYTE = 2'b00,
    FDR_CAT_BIT  = 2'b01,
    FDR_CAT_JUMP = 2'b10,
    FDR_CAT_LIT  = 2'b11
  } fdr_cat_e;

  typedef enum logic [1:0] {
    FDR_Q1 = 2'b00,
    FDR_Q2 = 2'b01,
    FDR_Q3 = 2'b10,
    FDR_Q4 = 2'b11
  } fdr_phase_e;

  typedef enum logic [1:0] {
    FDR_BUB_NONE = 2'b00,
    FDR_BUB_SKIP = 2'b01,
    FDR_BUB_JUMP = 2'b10
  } fdr_bub_e;

  typedef struct packed {
    fdr_cat_e    cat;
    logic [3:0]  op;
    logic        dest;
    logic [2:0]  bitsel;
    logic [6:0]  faddr;
    logic [7:0]  lit8;
    logic [10:0] lit11;
  } fdr_dec_s;

  function automatic fdr_dec_s fdr_decode(input logic [13:0] iw);
    fdr_dec_s d;
    d.cat    = fdr_cat_e'(iw[`FDR_CAT_MSB:`FDR_CAT_LSB]);
    d.op     = iw[`FDR_OP_MSB:`FDR_OP_LSB];
    d.dest   = iw[`FDR_DEST_BIT];
    d.bitsel = iw[`FDR_BSEL_MSB:`FDR_BSEL_LSB];
    d.faddr  = iw[`FDR_FA_MSB:0];
    d.lit8   = iw[`FDR_LIT8_MSB:0];
    d.lit11  = iw[`FDR_LIT11_MSB:0];
    return d;
  endfunction : fdr_decode

endpackage : fdr_pkg
`default_nettype wire

// File: testbench/fdr_prog_mem.sv
// Program memory model that feeds instruction words to the core.
`default_nettype none
module fdr_prog_mem #(
  parameter int AW = 13
) (
  // Clock
  input  wire logic          clk_i,
  // Fetch port
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          slow_i,
  output logic [13:0]        data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0]   mem [0:63];
  logic [AW-1:0] last_addr;

  always_ff @(negedge clk_i) begin
    last_addr <= addr_i;
  end

  // Slow mode shows a scrambled word for half a clock after each address change;
  // the word is valid well before the edge ending Q1, so only early sampling fails
  assign data_o = (slow_i && (addr_i != last_addr)) ? ~mem[addr_i[5:0]] : mem[addr_i[5:0]];
endmodule : fdr_prog_mem
`default_nettype wire

// File: testbench/instruction_format_decoder_tb.sv
// Self-checking bench for the decode and timing core.
`default_nettype none
module instruction_format_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_n_i;
  logic        slow;
  logic [12:0] prog_addr_o;
  logic [13:0] prog_data_i;
  logic [7:0]  port_pin_i;
  logic [7:0]  port_out_o;
  logic        port_change_flag_o;
  logic [7:0]  w_o;
  logic        carry_o;
  logic        zero_o;
  logic        file_rd_o;
  int          err_total;
  int          samples_checked;

  fdr_core i_fdr_core (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .port_pin_i(port_pin_i), .port_out_o(port_out_o), .port_change_flag_o(port_change_flag_o),
    .w_o(w_o), .carry_o(carry_o), .zero_o(zero_o), .file_rd_o(file_rd_o));

  fdr_prog_mem i_fdr_prog_mem (
    .clk_i(clk_i), .addr_i(prog_addr_o), .slow_i(slow), .data_o(prog_data_i));

  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // One instruction cycle: fetch address at its start, file reads counted over four clocks
  task automatic step(input int exp_addr, input int exp_rd);
    int rd;
    rd = 0;
    check(16'(prog_addr_o), 16'(exp_addr), "fetch address");
    repeat (4) begin
      @(negedge clk_i);
      if (file_rd_o === 1'b1) rd++;
    end
    if (exp_rd >= 0) check(16'(rd), 16'(exp_rd), "file reads");
  endtask : step

  function automatic logic [13:0] byte_op(input logic [3:0] op, input logic d,
                                          input logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction : byte_op

  function automatic logic [13:0] bit_op(input logic [1:0] op, input logic [2:0] b,
                                         input logic [6:0] f);
    return {2'b01, op, b, f};
  endfunction : bit_op

  task automatic run_program(input int n, input logic [7:0] k, input logic [2:0] b,
                             input logic [6:0] fa, input logic slow_mode);
    logic [13:0] p [0:21];
    logic [7:0]  k2;
    logic [7:0]  v;
    logic [7:0]  p1;
    logic [7:0]  h;
    k2 = 8'($urandom);
    p1 = 8'($urandom) | 8'h01;
    v  = 8'(k << 1) | (8'h01 << b);
    h  = 8'(k << 1) & ~(8'h01 << b);
    for (int a = 0; a < 64; a++) i_fdr_prog_mem.mem[a] = {6'b110000, 8'ha5};
    p = '{{6'b110000, k}, byte_op(4'h0, 1'b1, fa), byte_op(4'h1, 1'b0, 7'($urandom)),
          byte_op(4'h7, 1'b0, fa), byte_op(4'h7, 1'b1, fa), byte_op(4'h8, 1'b0, fa),
          bit_op(2'h1, b, fa), byte_op(4'h8, 1'b0, fa), bit_op(2'h3, b, fa),
          {6'b110000, 8'ha5}, bit_op(2'h0, b, fa), bit_op(2'h2, b, fa),
          {6'b110000, 8'ha5}, byte_op(4'h8, 1'b0, fa), byte_op(4'h0, 1'b1, 7'h06),
          {7'h00, 2'($urandom), 5'h00}, byte_op(4'h1, 1'b1, 7'h06), {3'b101, 11'd21},
          {6'b110000, 8'ha5}, {6'b110000, 8'ha5}, {6'b110000, 8'ha5}, {6'b110000, k2}};
    for (int a = 0; a < 22; a++) i_fdr_prog_mem.mem[a] = p[a];
    i_fdr_prog_mem.mem[22] = byte_op(4'h5, 1'b0, fa);
    i_fdr_prog_mem.mem[23] = {3'b100, 11'h01a};
    i_fdr_prog_mem.mem[26] = {6'b110100, k};
    slow = slow_mode;
    port_pin_i = p1;
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    step(0, 0);
    check(16'(w_o), 16'(k), "literal load");
    step(1, 1);
    step(2, 0);
    check(16'(w_o), 16'h0, "clear accumulator");
    check(16'(zero_o), 16'h1, "zero after clear");
    step(3, 1);
    check(16'(w_o), 16'(k), "add to accumulator");
    step(4, 1);
    check(16'(w_o), 16'(k), "add to file keeps accumulator");
    check(16'(carry_o), 16'(k[7]), "carry of add");
    step(5, 1);
    check(16'(w_o), 16'(8'(k << 1)), "file result");
    step(6, 1);
    step(7, 1);
    check(16'(w_o), 16'(v), "bit set");
    step(8, 1);
    step(9, 0);
    check(16'(w_o), 16'(v), "skipped word not run");
    step(10, 1);
    step(11, 1);
    step(12, 0);
    step(13, 1);
    check(16'(w_o), 16'(h), "bit clear");
    check(16'(port_change_flag_o), 16'h1, "mismatch before port read");
    step(14, 1);
    check(16'(port_out_o), 16'(h), "port write");
    check(16'(port_change_flag_o), 16'h0, "write also reads port");
    port_pin_i = p1 ^ (8'h01 << b);
    step(15, 0);
    check(16'(w_o), 16'(h), "no-operation with don't-care bits");
    check(16'(port_change_flag_o), 16'h1, "new mismatch");
    step(16, 1);
    check(16'(port_out_o), 16'h0, "port clear");
    check(16'(port_change_flag_o), 16'h0, "clear ends mismatch");
    step(17, 0);
    step(21, 0);
    check(16'(w_o), 16'(h), "jump dummy cycle");
    step(21, 0);
    check(16'(w_o), 16'(k2), "jump target");
    step(22, 1);
    check(16'(w_o), 16'(k2 & h), "and with file");
    step(23, 0);
    step(26, 0);
    step(26, 0);
    check(16'(w_o), 16'(k), "literal on return");
    step(24, 0);
    check(16'(w_o), 16'(k), "return dummy cycle");
    step(24, 0);
    check(16'(w_o), 16'h00a5, "return address");
    $display("test %0d done", n);
  endtask : run_program

  initial begin
    #10000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    slow = 1'b0;
    port_pin_i = 8'h00;
    void'($urandom(32'h8393955a));
    @(negedge clk_i);
    run_program(0, 8'h80, 3'h7, 7'h7f, 1'b0);
    run_program(1, 8'($urandom), 3'($urandom), 7'h20 + 7'($urandom % 80), 1'b1);
    run_program(2, 8'($urandom), 3'($urandom), 7'h20 + 7'($urandom % 80), 1'b0);
    final_report();
  end
endmodule : instruction_format_decoder_tb
`default_nettype wire
